// File: hw/asc_seq_ctrl.sv
// sequencer channel control and status register bank
//
// The plain strobed port and the placing of the registers were left to the implementer.
`default_nettype none
module asc_seq_ctrl import asc_pkg::*; #(
    parameter int IPTR_W = 14,
    parameter int NUM_UREG = 16,
    parameter int WAVE_W = 30
) (
    // clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    // register port
    input wire asc_bus_req_t i_bus,
    output logic [31:0] o_rdata,
    // sequencer core side
    input wire asc_core_st_t i_core,
    input wire logic [IPTR_W-1:0] i_instruction_pointer,
    input wire logic i_all_sync_ready,
    input wire logic i_rate_ovr_valid,
    input wire logic [3:0] i_rate_ovr_code,
    input wire logic i_ureg_wr,
    input wire logic [$clog2(NUM_UREG)-1:0] i_ureg_idx,
    input wire logic [31:0] i_ureg_wdata,
    output logic [31:0] o_ureg_rdata,
    // control outputs to the core
    output logic o_single_run,
    output logic o_sync_en,
    output logic o_exec_hold,
    output logic o_sync_ready,
    output logic [3:0] o_rate_code,
    output logic o_fetch_main,
    output logic o_main_large,
    output logic o_ready,
    // interrupt
    output logic o_irq
);
    // refuse parameter values the logic cannot serve
    if (IPTR_W < 1 || IPTR_W > 15 || NUM_UREG < 2 || NUM_UREG > 32 || WAVE_W < 19 || WAVE_W > 30) begin : g_bad_param
        $error("asc_seq_ctrl: unsupported parameters");
    end

    localparam int UI_W = $clog2(NUM_UREG);

    logic single_r;
    logic sync_r;
    logic [3:0] rate_r;
    logic [3:0] rate_ovr_r;
    logic ovr_act_r;
    logic memsel_r;
    logic [15:0] progsz_r;
    logic [WAVE_W-1:0] wavesz_r;
    logic ready_r;
    logic [ASC_ST_W-1:0] state_r;
    logic [IPTR_W-1:0] iptr_r;
    logic trig_r;
    logic play_r;
    logic [ASC_EV_W-1:0] ist_r;
    logic [ASC_EV_W-1:0] imask_r;
    logic [ASC_EV_W-1:0] ev_nxt;
    logic [31:0] ureg_r [NUM_UREG];
    logic [31:0] rdata_nxt;
    logic [31:0] ureg_rd_r;
    logic trig_d_r;
    logic err_d_r;
    logic done_d_r;
    logic in_ureg;
    logic [UI_W-1:0] bus_uidx;
    logic ctrl_wr;
    logic [7:0] ureg_ofs;

    assign ctrl_wr = i_bus.wr && i_bus.addr == ASC_OFS_CTRL;
    // slot index counted from the first user register, not from address zero
    assign ureg_ofs = i_bus.addr - ASC_OFS_UREG0;
    assign bus_uidx = ureg_ofs[UI_W+1:2];
    assign in_ureg = i_bus.addr >= ASC_OFS_UREG0 && i_bus.addr < ASC_OFS_UREG0 + 8'(4 * NUM_UREG);

    // host settings
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            single_r <= 1'b0;
            sync_r <= 1'b0;
            rate_r <= ASC_RATE_RST;
            memsel_r <= 1'b0;
        end else if (i_ce && i_bus.wr) begin
            if (i_bus.addr == ASC_OFS_SINGLE) begin
                single_r <= i_bus.wdata[0];
            end
            if (i_bus.addr == ASC_OFS_SYNC) begin
                sync_r <= i_bus.wdata[0];
            end
            if (i_bus.addr == ASC_OFS_RATE && i_bus.wdata[3:0] <= 4'(ASC_RATE_MAX) && i_bus.wdata[31:4] == '0) begin
                rate_r <= i_bus.wdata[3:0];
            end
            if (i_bus.addr == ASC_OFS_MEMSEL) begin
                memsel_r <= i_bus.wdata[0];
            end
        end
    end

    // program and waveform size, loaded status
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            progsz_r <= '0;
            wavesz_r <= '0;
            ready_r <= 1'b0;
        end else if (i_ce) begin
            if (i_bus.wr && i_bus.addr == ASC_OFS_PROGSZ && i_bus.wdata <= 32'(ASC_INSTR_CAP)) begin
                progsz_r <= i_bus.wdata[15:0];
            end
            if (i_bus.wr && i_bus.addr == ASC_OFS_WAVESZ) begin
                wavesz_r <= i_bus.wdata[WAVE_W-1:0];
            end
            if (ctrl_wr && i_bus.wdata[ASC_CTRL_CLEAR]) begin
                ready_r <= 1'b0;
                progsz_r <= '0;
            end else if (ctrl_wr && i_bus.wdata[ASC_CTRL_LOAD] && progsz_r != '0) begin
                ready_r <= 1'b1;
            end
        end
    end

    // rate override from the running program
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rate_ovr_r <= ASC_RATE_RST;
            ovr_act_r <= 1'b0;
        end else if (i_ce) begin
            if (!i_core.running) begin
                ovr_act_r <= 1'b0;
            end else if (i_rate_ovr_valid && i_rate_ovr_code <= 4'(ASC_RATE_MAX)) begin
                rate_ovr_r <= i_rate_ovr_code;
                ovr_act_r <= 1'b1;
            end
        end
    end

    // live status capture
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_r <= '0;
            iptr_r <= '0;
            trig_r <= 1'b0;
            play_r <= 1'b0;
        end else if (i_ce) begin
            state_r[ASC_ST_RUN] <= i_core.running;
            state_r[ASC_ST_RSV] <= 1'b0;
            state_r[ASC_ST_TWAIT] <= i_core.trig_wait;
            state_r[ASC_ST_ERR] <= i_core.error;
            state_r[ASC_ST_SWAIT] <= i_core.running && sync_r && !i_all_sync_ready;
            iptr_r <= i_instruction_pointer;
            trig_r <= i_core.triggered;
            play_r <= i_core.playing;
        end
    end

    // user registers, sequencer write wins on the same index
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            for (int k = 0; k < NUM_UREG; k++) begin
                ureg_r[k] <= '0;
            end
            ureg_rd_r <= '0;
        end else if (i_ce) begin
            if (i_bus.wr && in_ureg) begin
                ureg_r[bus_uidx] <= i_bus.wdata;
            end
            if (i_ureg_wr) begin
                ureg_r[i_ureg_idx] <= i_ureg_wdata;
            end
            ureg_rd_r <= ureg_r[i_ureg_idx];
        end
    end

    // event edges
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            trig_d_r <= 1'b0;
            err_d_r <= 1'b0;
            done_d_r <= 1'b0;
        end else if (i_ce) begin
            trig_d_r <= i_core.triggered;
            err_d_r <= i_core.error;
            done_d_r <= i_core.done;
        end
    end

    always_comb begin
        ev_nxt = '0;
        ev_nxt[ASC_EV_TRIG] = i_core.triggered && !trig_d_r;
        ev_nxt[ASC_EV_ERR] = i_core.error && !err_d_r;
        ev_nxt[ASC_EV_DONE] = i_core.done && !done_d_r;
    end

    // sticky interrupt status, set beats write-one clear
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ist_r <= '0;
            imask_r <= '0;
        end else if (i_ce) begin
            if (i_bus.wr && i_bus.addr == ASC_OFS_IRQ_STAT) begin
                ist_r <= (ist_r & ~i_bus.wdata[ASC_EV_W-1:0]) | ev_nxt;
            end else begin
                ist_r <= ist_r | ev_nxt;
            end
            if (i_bus.wr && i_bus.addr == ASC_OFS_IRQ_MASK) begin
                imask_r <= i_bus.wdata[ASC_EV_W-1:0];
            end
        end
    end

    // read mux
    always_comb begin
        rdata_nxt = '0;
        unique case (i_bus.addr)
            ASC_OFS_STATE: rdata_nxt = 32'(state_r);
            ASC_OFS_IPTR: rdata_nxt = 32'(iptr_r);
            ASC_OFS_TRIG: rdata_nxt = 32'(trig_r);
            ASC_OFS_SINGLE: rdata_nxt = 32'(single_r);
            ASC_OFS_SYNC: rdata_nxt = 32'(sync_r);
            ASC_OFS_RATE: rdata_nxt = 32'(rate_r);
            ASC_OFS_PLAY: rdata_nxt = 32'(play_r);
            ASC_OFS_PROGSZ: rdata_nxt = 32'(progsz_r);
            ASC_OFS_WAVESZ: rdata_nxt = 32'(wavesz_r);
            ASC_OFS_MEMSEL: rdata_nxt = 32'(memsel_r);
            ASC_OFS_READY: rdata_nxt = 32'(ready_r);
            ASC_OFS_IRQ_STAT: rdata_nxt = 32'(ist_r);
            ASC_OFS_IRQ_MASK: rdata_nxt = 32'(imask_r);
            default: rdata_nxt = in_ureg ? ureg_r[bus_uidx] : 32'h0000_0000;
        endcase
    end

    // read data one cycle after strobe
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (i_ce) begin
            o_rdata <= i_bus.rd ? rdata_nxt : 32'h0000_0000;
        end
    end

    assign o_single_run = single_r;
    assign o_sync_en = sync_r;
    assign o_sync_ready = ready_r;
    assign o_exec_hold = sync_r && !i_all_sync_ready;
    assign o_rate_code = ovr_act_r ? rate_ovr_r : rate_r;
    // fetch from main memory above cache
    assign o_fetch_main = wavesz_r > WAVE_W'(ASC_CACHE_CAP);
    assign o_main_large = memsel_r;
    assign o_ready = ready_r;
    assign o_ureg_rdata = ureg_rd_r;
    assign o_irq = |(ist_r & imask_r);

    // assertions
    property p_rsv_zero;
        @(posedge i_clk_sys) disable iff (i_rst) state_r[ASC_ST_RSV] == 1'b0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved status bit set");

    property p_run;
        @(posedge i_clk_sys) disable iff (i_rst) i_ce |=> state_r[ASC_ST_RUN] == $past(i_core.running);
    endproperty
    a_run: assert property (p_run) else $error("running bit wrong");

    property p_twait;
        @(posedge i_clk_sys) disable iff (i_rst) i_ce |=> state_r[ASC_ST_TWAIT] == $past(i_core.trig_wait);
    endproperty
    a_twait: assert property (p_twait) else $error("trigger wait bit wrong");

    property p_err;
        @(posedge i_clk_sys) disable iff (i_rst) i_ce |=> state_r[ASC_ST_ERR] == $past(i_core.error);
    endproperty
    a_err: assert property (p_err) else $error("error bit wrong");

    property p_swait;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_ce && i_core.running && sync_r && !i_all_sync_ready |=> state_r[ASC_ST_SWAIT];
    endproperty
    a_swait: assert property (p_swait) else $error("sync wait bit missing");

    property p_hold;
        @(posedge i_clk_sys) disable iff (i_rst) o_exec_hold == (sync_r && !i_all_sync_ready);
    endproperty
    a_hold: assert property (p_hold) else $error("sync hold wrong");

    property p_rate;
        @(posedge i_clk_sys) disable iff (i_rst) o_rate_code <= 4'(ASC_RATE_MAX);
    endproperty
    a_rate: assert property (p_rate) else $error("rate code out of range");

    property p_clear;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_ce && ctrl_wr && i_bus.wdata[ASC_CTRL_CLEAR] |=> !o_ready;
    endproperty
    a_clear: assert property (p_clear) else $error("ready after clear");

    property p_rdlat;
        @(posedge i_clk_sys) disable iff (i_rst) i_ce && !i_bus.rd |=> o_rdata == 32'h0000_0000;
    endproperty
    a_rdlat: assert property (p_rdlat) else $error("read data outside slot");

    // pointer and flags follow the core one cycle later
    property p_iptr;
        @(posedge i_clk_sys) disable iff (i_rst) i_ce |=> iptr_r == $past(i_instruction_pointer);
    endproperty
    a_iptr: assert property (p_iptr) else $error("instruction pointer wrong");

    property p_trig;
        @(posedge i_clk_sys) disable iff (i_rst) i_ce |=> trig_r == $past(i_core.triggered);
    endproperty
    a_trig: assert property (p_trig) else $error("triggered flag wrong");

    property p_play;
        @(posedge i_clk_sys) disable iff (i_rst) i_ce |=> play_r == $past(i_core.playing);
    endproperty
    a_play: assert property (p_play) else $error("playing flag wrong");

    // sync wait bit drops once its condition is gone
    property p_swait_off;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_ce && !(i_core.running && sync_r && !i_all_sync_ready) |=> !state_r[ASC_ST_SWAIT];
    endproperty
    a_swait_off: assert property (p_swait_off) else $error("sync wait bit stuck");

    // load with a program present makes the bank ready
    property p_load;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_ce && ctrl_wr && !i_bus.wdata[ASC_CTRL_CLEAR] && i_bus.wdata[ASC_CTRL_LOAD]
            && progsz_r != '0 |=> o_ready;
    endproperty
    a_load: assert property (p_load) else $error("not ready after load");

    // out-of-range rate writes leave the host code alone
    property p_rate_keep;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_ce && i_bus.wr && i_bus.addr == ASC_OFS_RATE && i_bus.wdata > 32'(ASC_RATE_MAX) |=> $stable(rate_r);
    endproperty
    a_rate_keep: assert property (p_rate_keep) else $error("illegal rate code taken");

    // program override lapses once the sequencer stops
    property p_ovr_end;
        @(posedge i_clk_sys) disable iff (i_rst) i_ce && !i_core.running |=> !ovr_act_r;
    endproperty
    a_ovr_end: assert property (p_ovr_end) else $error("override outlived the run");

    // sequencer write lands, beating a host write to the same slot
    property p_ureg_seq;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_ce && i_ureg_wr |=> ureg_r[$past(i_ureg_idx)] == $past(i_ureg_wdata);
    endproperty
    a_ureg_seq: assert property (p_ureg_seq) else $error("sequencer user write lost");

    c_trig: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(trig_r));
    c_swait: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(state_r[ASC_ST_SWAIT]));
    c_irq: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(o_irq));
    c_ovr: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(ovr_act_r));
    c_load: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(o_ready));
endmodule : asc_seq_ctrl
`default_nettype wire

// File: hw/asc_pkg.sv
// package of constants and types for the sequencer control and status bank
`default_nettype none
package asc_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] ASC_OFS_STATE = 8'h00;
    localparam logic [7:0] ASC_OFS_IPTR = 8'h04;
    localparam logic [7:0] ASC_OFS_TRIG = 8'h08;
    localparam logic [7:0] ASC_OFS_SINGLE = 8'h0c;
    localparam logic [7:0] ASC_OFS_SYNC = 8'h10;
    localparam logic [7:0] ASC_OFS_RATE = 8'h14;
    localparam logic [7:0] ASC_OFS_PLAY = 8'h18;
    localparam logic [7:0] ASC_OFS_PROGSZ = 8'h1c;
    localparam logic [7:0] ASC_OFS_WAVESZ = 8'h20;
    localparam logic [7:0] ASC_OFS_MEMSEL = 8'h24;
    localparam logic [7:0] ASC_OFS_READY = 8'h28;
    localparam logic [7:0] ASC_OFS_CTRL = 8'h2c;
    localparam logic [7:0] ASC_OFS_IRQ_STAT = 8'h30;
    localparam logic [7:0] ASC_OFS_IRQ_MASK = 8'h34;
    localparam logic [7:0] ASC_OFS_UREG0 = 8'h40;
    // status word bit positions
    localparam int ASC_ST_RUN = 0;
    localparam int ASC_ST_RSV = 1;
    localparam int ASC_ST_TWAIT = 2;
    localparam int ASC_ST_ERR = 3;
    localparam int ASC_ST_SWAIT = 4;
    localparam int ASC_ST_W = 5;
    // control register bits (write one pulses)
    localparam int ASC_CTRL_LOAD = 0;
    localparam int ASC_CTRL_CLEAR = 1;
    // event bits in the interrupt status
    localparam int ASC_EV_TRIG = 0;
    localparam int ASC_EV_ERR = 1;
    localparam int ASC_EV_DONE = 2;
    localparam int ASC_EV_W = 3;
    // capacities
    localparam int ASC_INSTR_CAP = 16384;
    localparam int ASC_CACHE_CAP = 262144;
    localparam int ASC_MAIN_SMALL = 67108864;
    localparam int ASC_MAIN_LARGE = 536870912;
    localparam int ASC_RATE_MAX = 13;
    localparam logic [3:0] ASC_RATE_RST = 4'h0;
    localparam logic [31:0] ASC_PERCENT = 32'h0000_0064;
    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } asc_bus_req_t;
    // sequencer core status inputs
    typedef struct packed {
        logic running;
        logic trig_wait;
        logic error;
        logic triggered;
        logic playing;
        logic done;
    } asc_core_st_t;
endpackage : asc_pkg
`default_nettype wire

// File: dv/asc_seq_ctrl_tb.sv
// self-checking testbench for the sequencer control and status bank
`default_nettype none
module asc_seq_ctrl_tb import asc_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    // stimulus
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    asc_bus_req_t i_bus = '0;
    asc_core_st_t i_core = '0;
    logic [13:0] i_instruction_pointer = 14'h0000;
    logic i_all_sync_ready = 1'b0;
    logic i_rate_ovr_valid = 1'b0;
    logic [3:0] i_rate_ovr_code = 4'h0;
    logic i_ureg_wr = 1'b0;
    logic [3:0] i_ureg_idx = 4'h0;
    logic [31:0] i_ureg_wdata = 32'h0000_0000;
    // observed outputs
    logic [31:0] o_rdata;
    logic [31:0] o_ureg_rdata;
    logic o_single_run;
    logic o_sync_en;
    logic o_exec_hold;
    logic o_sync_ready;
    logic [3:0] o_rate_code;
    logic o_fetch_main;
    logic o_main_large;
    logic o_ready;
    logic o_irq;
    // bookkeeping
    int bad_count = 0;
    int checks = 0;
    int seed = 95;
    int k;
    logic [31:0] exp_q[$];
    logic rd_q = 1'b0;
    logic sync_m;
    logic [31:0] v;
    asc_core_st_t c;
    logic [7:0] ofs[11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h28, 8'hfc};

    asc_seq_ctrl #(.IPTR_W(14), .NUM_UREG(16), .WAVE_W(30)) asc_seq_ctrl_i (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_bus(i_bus), .o_rdata(o_rdata),
        .i_core(i_core), .i_instruction_pointer(i_instruction_pointer), .i_all_sync_ready(i_all_sync_ready),
        .i_rate_ovr_valid(i_rate_ovr_valid), .i_rate_ovr_code(i_rate_ovr_code), .i_ureg_wr(i_ureg_wr),
        .i_ureg_idx(i_ureg_idx), .i_ureg_wdata(i_ureg_wdata), .o_ureg_rdata(o_ureg_rdata),
        .o_single_run(o_single_run), .o_sync_en(o_sync_en), .o_exec_hold(o_exec_hold),
        .o_sync_ready(o_sync_ready), .o_rate_code(o_rate_code), .o_fetch_main(o_fetch_main),
        .o_main_large(o_main_large), .o_ready(o_ready), .o_irq(o_irq)
    );

    // 100 MHz clock
    always #5 i_clk_sys = ~i_clk_sys;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    // one bus cycle, launched just after a rising edge
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_bus <= {a, d, w, r};
    endtask : op

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        op(1'b1, 1'b0, a, d);
    endtask : wr

    // read notes its expectation for the watching process
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        op(1'b0, 1'b1, a, 32'h0000_0000);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) op(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    endtask : idle

    task automatic settle;
        idle(1);
        @(negedge i_clk_sys);
    endtask : settle

    // core levels change together with a bus release
    task automatic core_set(input asc_core_st_t cs, input logic rdy, input logic [13:0] ip);
        @(posedge i_clk_sys);
        i_bus <= '0;
        i_core <= cs;
        i_all_sync_ready <= rdy;
        i_instruction_pointer <= ip;
    endtask : core_set

    // read data stand only in the cycle after the strobe
    always @(posedge i_clk_sys) begin
        rd_q <= i_bus.rd && i_ce && !i_rst;
    end
    always @(negedge i_clk_sys) begin
        if (rd_q && exp_q.size() > 0) begin
            chk(o_rdata, exp_q.pop_front(), "read data");
        end else if (!i_rst) begin
            chk(o_rdata, 32'h0000_0000, "idle read data");
        end
    end

    // hang guard
    initial begin
        #500000;
        bad_count++;
        give_verdict();
    end

    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        settle();
        chk({o_single_run, o_sync_en, o_exec_hold, o_ready, o_irq, o_fetch_main, o_rate_code}, 32'h0, "reset");
        foreach (ofs[i]) rd(ofs[i], 32'h0000_0000);
        wr(ASC_OFS_STATE, 32'hffff_ffff);
        // random core states, sync gate on for the second half
        for (k = 0; k < 12; k++) begin
            v = $random(seed);
            c = asc_core_st_t'(v[5:0]);
            sync_m = (k >= 6);
            if (k == 6) wr(ASC_OFS_SYNC, 32'h0000_0001);
            core_set(c, v[6], v[29:16]);
            settle();
            chk({o_sync_en, o_exec_hold}, {30'h0, sync_m, sync_m && !v[6]}, "sync hold");
            rd(ASC_OFS_STATE, {27'h0, c.running && sync_m && !v[6], c.error, c.trig_wait, 1'b0, c.running});
            rd(ASC_OFS_IPTR, {18'h0, v[29:16]});
            rd(ASC_OFS_TRIG, {31'h0, c.triggered});
            rd(ASC_OFS_PLAY, {31'h0, c.playing});
        end
        wr(ASC_OFS_SYNC, 32'h0000_0000);
        core_set('0, 1'b1, 14'h0000);
        // one-shot setting, and a write with the enable low
        wr(ASC_OFS_SINGLE, 32'h0000_0001);
        settle();
        chk(o_single_run, 1'b1, "single run");
        @(posedge i_clk_sys);
        i_ce <= 1'b0;
        i_bus <= {ASC_OFS_SINGLE, 32'h0, 1'b1, 1'b0};
        @(posedge i_clk_sys);
        i_ce <= 1'b1;
        i_bus <= '0;
        rd(ASC_OFS_SINGLE, 32'h0000_0001);
        // every rate code, then one beyond the range
        for (k = 0; k <= 14; k++) begin
            wr(ASC_OFS_RATE, 32'(k));
            rd(ASC_OFS_RATE, 32'(k > ASC_RATE_MAX ? ASC_RATE_MAX : k));
        end
        settle();
        chk(o_rate_code, 4'hd, "host rate");
        core_set(asc_core_st_t'(6'h20), 1'b1, 14'h0000);
        @(posedge i_clk_sys);
        i_rate_ovr_valid <= 1'b1;
        i_rate_ovr_code <= 4'h5;
        @(posedge i_clk_sys);
        i_rate_ovr_valid <= 1'b0;
        settle();
        chk(o_rate_code, 4'h5, "rate override");
        core_set('0, 1'b1, 14'h0000);
        idle(2);
        @(negedge i_clk_sys);
        chk(o_rate_code, 4'hd, "rate restored");
        // user registers from both sides, then a same-cycle collision
        v = $random(seed);
        wr(ASC_OFS_UREG0 + 8'h0c, v);
        @(posedge i_clk_sys);
        i_bus <= '0;
        i_ureg_idx <= 4'h3;
        settle();
        chk(o_ureg_rdata, v, "sequencer read");
        @(posedge i_clk_sys);
        i_ureg_wr <= 1'b1;
        i_ureg_idx <= 4'h5;
        i_ureg_wdata <= ~v;
        i_bus <= {ASC_OFS_UREG0 + 8'h14, v, 1'b1, 1'b0};
        @(posedge i_clk_sys);
        i_ureg_wr <= 1'b0;
        i_bus <= '0;
        rd(ASC_OFS_UREG0 + 8'h14, ~v);
        // program size and readiness
        wr(ASC_OFS_CTRL, 32'h0000_0001);
        rd(ASC_OFS_READY, 32'h0000_0000);
        wr(ASC_OFS_PROGSZ, 32'(ASC_INSTR_CAP));
        wr(ASC_OFS_PROGSZ, 32'(ASC_INSTR_CAP + 1));
        rd(ASC_OFS_PROGSZ, 32'(ASC_INSTR_CAP));
        wr(ASC_OFS_CTRL, 32'h0000_0001);
        rd(ASC_OFS_READY, 32'h0000_0001);
        settle();
        chk({o_ready, o_sync_ready}, 2'b11, "ready outputs");
        wr(ASC_OFS_CTRL, 32'h0000_0003);
        rd(ASC_OFS_READY, 32'h0000_0000);
        rd(ASC_OFS_PROGSZ, 32'h0000_0000);
        // waveform cache boundary and main memory size
        wr(ASC_OFS_WAVESZ, 32'(ASC_CACHE_CAP));
        settle();
        chk(o_fetch_main, 1'b0, "cache fits");
        wr(ASC_OFS_WAVESZ, 32'(ASC_CACHE_CAP + 1));
        wr(ASC_OFS_MEMSEL, 32'h0000_0001);
        settle();
        chk({o_fetch_main, o_main_large}, 2'b11, "main memory");
        // each event raises its sticky bit; event one is masked
        idle(2);
        wr(ASC_OFS_IRQ_STAT, 32'h0000_0007);
        wr(ASC_OFS_IRQ_MASK, 32'h0000_0005);
        for (k = 0; k < 3; k++) begin
            c = '0;
            c.triggered = (k == ASC_EV_TRIG);
            c.error = (k == ASC_EV_ERR);
            c.done = (k == ASC_EV_DONE);
            core_set(c, 1'b1, 14'h0000);
            idle(2);
            @(negedge i_clk_sys);
            chk(o_irq, k != ASC_EV_ERR, "irq raised");
            rd(ASC_OFS_IRQ_STAT, 32'h1 << k);
            wr(ASC_OFS_IRQ_STAT, 32'h1 << k);
            core_set('0, 1'b1, 14'h0000);
            settle();
            chk(o_irq, 1'b0, "irq cleared");
        end
        // reset in mid-run returns every setting to its reset value
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        settle();
        chk({o_single_run, o_main_large, o_fetch_main, o_ready, o_irq, o_rate_code}, 32'h0, "mid-run reset");
        idle(3);
        give_verdict();
    end
endmodule : asc_seq_ctrl_tb
`default_nettype wire
